// ---- design/cpr_pkg.sv ----
// Purpose: Shared constants for the configuration PROM readout block.
// Assumes: 40 MHz system clock; config_clock arrives from the FPGA as a link clock.
// Notes: Times are kept in their own unit; cycle counts are derived from them.
//
// Notes on behaviour
// - Reconfigure pulls config_trigger_n low 300-500 ns
// - Control register selects serial or parallel output
// - Serial output, one bit per clock, by default
// - Transfer follows rising config_clock edges only
// - Each valid edge advances address and bit counters; here bit_q steps only in serial mode, addr_q on clk per FIFO word
// - After last bit: cascade low, data floats
// - Low chip_enable_n enables this device's data
// - Low output_enable_reset clears the address counter
// - Power-up holds output_enable_reset low about 1 ms
// - Brownout below 2.0 V resets readout; the mode register keeps its value
// - output_enable_reset polarity is fixed, low resets
// - High chip_enable_n means low-power standby
// - Standby keeps data floating regardless of reset pin
// - Count to terminal_count, then hold, float, cascade
// - Control bits writable without touching the array
// - Reconfigure instruction code is 11101110
// - Parallel mode gives one byte per clock
package cpr_pkg;

  // System clock
  localparam int CLK_PERIOD_NS = 25;

  // Reconfigure pulse window and the nominal pulse taken inside it
  localparam int TRIG_MIN_NS = 300;
  localparam int TRIG_MAX_NS = 500;
  localparam int TRIG_PULSE_NS = (TRIG_MIN_NS + TRIG_MAX_NS) / 2;
  localparam int TRIG_CYCLES = (TRIG_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Power-up hold of the reset pin
  localparam int POWERUP_MS = 1;
  localparam int POWERUP_CYCLES = POWERUP_MS * 1000000 / CLK_PERIOD_NS;

  // Instruction code that launches FPGA configuration
  localparam logic [7:0] INSTR_RECONFIG = 8'hee;

  // Output mode after reset: serial
  localparam logic MODE_PARALLEL_RESET = 1'b0;

  // Stream layout: one byte plus a last-byte marker per FIFO word
  localparam int BYTE_W = 8;
  localparam int LAST_POS = 8;
  localparam int WORD_W = 9;
  localparam int FIFO_DEPTH = 8;

  // Stored array size in bytes (plain default)
  localparam int ARRAY_BYTES = 64;

endpackage : cpr_pkg

// ---- design/cpr_top.sv ----
// Purpose: Readout sequencer of a configuration PROM feeding an FPGA.
// Assumes: Pins from outside are synchronised; TAP logic gives same-clock strobes.
// Notes: Array bytes cross to the config_clock domain through a gray-pointer FIFO.

// Dual-clock FIFO with gray-coded pointers
module cpr_fifo #(
  parameter int WIDTH = cpr_pkg::WORD_W,
  parameter int DEPTH = cpr_pkg::FIFO_DEPTH
) (
  input wire logic wclk,
  input wire logic wrst,
  input wire logic w_valid,
  output logic w_ready,
  input wire logic [WIDTH-1:0] w_data,
  input wire logic rclk,
  input wire logic rrst,
  output logic r_valid,
  input wire logic r_ready,
  output logic [WIDTH-1:0] r_data
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 4 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("cpr_fifo: DEPTH must be a power of two, at least 4");
  end

  function automatic logic [AW:0] bin2gray(input logic [AW:0] b);
    bin2gray = b ^ (b >> 1);
  endfunction : bin2gray

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wbin_q, wgray_q, rbin_q, rgray_q;
  logic [AW:0] rg_w1_q, rg_w2_q, wg_r1_q, wg_r2_q;
  logic [AW:0] wbin_d, rbin_d;

  // Full when the write pointer laps the read pointer by one turn
  assign w_ready = wgray_q != {~rg_w2_q[AW:AW-1], rg_w2_q[AW-2:0]};
  assign r_valid = rgray_q != wg_r2_q;
  assign r_data = mem_q[rbin_q[AW-1:0]];
  assign wbin_d = wbin_q + {{AW{1'b0}}, 1'b1};
  assign rbin_d = rbin_q + {{AW{1'b0}}, 1'b1};

  // Write pointer
  always_ff @(posedge wclk) begin
    if (wrst) begin
      wbin_q <= '0;
      wgray_q <= '0;
    end else if (w_valid && w_ready) begin
      wbin_q <= wbin_d;
      wgray_q <= bin2gray(wbin_d);
    end
  end

  // Storage; no reset needed, pointers guard it
  always_ff @(posedge wclk) begin
    if (w_valid && w_ready) begin
      mem_q[wbin_q[AW-1:0]] <= w_data;
    end
  end

  // Read pointer into the write domain
  always_ff @(posedge wclk) begin
    if (wrst) begin
      rg_w1_q <= '0;
      rg_w2_q <= '0;
    end else begin
      rg_w1_q <= rgray_q;
      rg_w2_q <= rg_w1_q;
    end
  end

  // Read pointer
  always_ff @(posedge rclk) begin
    if (rrst) begin
      rbin_q <= '0;
      rgray_q <= '0;
    end else if (r_valid && r_ready) begin
      rbin_q <= rbin_d;
      rgray_q <= bin2gray(rbin_d);
    end
  end

  // Write pointer into the read domain
  always_ff @(posedge rclk) begin
    if (rrst) begin
      wg_r1_q <= '0;
      wg_r2_q <= '0;
    end else begin
      wg_r1_q <= wgray_q;
      wg_r2_q <= wg_r1_q;
    end
  end
endmodule : cpr_fifo

// Readout top
module cpr_top #(
  parameter int ARRAY_BYTES = cpr_pkg::ARRAY_BYTES,
  parameter int POWERUP_CYCLES = cpr_pkg::POWERUP_CYCLES,
  parameter int FIFO_DEPTH = cpr_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic config_clock,
  input wire logic output_enable_reset_in,
  output logic output_enable_reset_out,
  output logic output_enable_reset_oe_n,
  input wire logic chip_enable_n,
  output logic cascade_enable_out_n,
  output logic [7:0] data_lines_out,
  output logic data_lines_oe_n,
  output logic config_trigger_n,
  input wire logic supply_low,
  input wire logic [7:0] jtag_instr,
  input wire logic jtag_update,
  input wire logic ctrl_wr,
  input wire logic ctrl_parallel,
  input wire logic prog_we,
  input wire logic [15:0] prog_addr,
  input wire logic [7:0] prog_data,
  output logic standby,
  output logic parallel_mode
);
  localparam int AW = $clog2(ARRAY_BYTES + 1);
  localparam int PW = $clog2(POWERUP_CYCLES + 1);
  localparam logic [AW-1:0] ADDR_LAST = AW'(ARRAY_BYTES - 1);
  localparam logic [AW-1:0] ADDR_END = AW'(ARRAY_BYTES);
  localparam logic [PW-1:0] PU_LAST = PW'(POWERUP_CYCLES - 1);
  localparam logic [4:0] TRIG_LAST = 5'(cpr_pkg::TRIG_CYCLES - 1);

  // The array index drops the top address bit, so the size must be a power of two
  if (ARRAY_BYTES < 2 || ARRAY_BYTES > 65536 || (1 << (AW - 1)) != ARRAY_BYTES
      || POWERUP_CYCLES < 1 || cpr_pkg::TRIG_CYCLES < 1
      || cpr_pkg::TRIG_CYCLES > 32) begin : g_bad_param
    $error("cpr_top: parameter out of supported range");
  end

  // System clock domain
  logic [7:0] array_q [ARRAY_BYTES];
  logic [3:0] pin_s1_q, pin_s2_q;
  logic bo_s, oe_s, ce_s, done_s;
  logic rst_int;
  logic [PW-1:0] pu_cnt_q;
  logic ready_q;
  logic act_q;
  logic [AW-1:0] addr_q;
  logic parallel_q;
  logic trig_active_q;
  logic [4:0] trig_cnt_q;
  logic oe_n_q, casc_n_q;
  logic done_l_q; // Link-side flag, read here only through the synchroniser
  logic w_valid, w_ready;
  logic [cpr_pkg::WORD_W-1:0] w_word;

  // Pins and the link's done flag pass two flops; stage one feeds only stage two
  always_ff @(posedge clk) begin
    pin_s1_q <= {supply_low, chip_enable_n, output_enable_reset_in, done_l_q};
    pin_s2_q <= pin_s1_q;
  end
  assign bo_s = pin_s2_q[3];
  assign ce_s = pin_s2_q[2];
  assign oe_s = pin_s2_q[1];
  assign done_s = pin_s2_q[0];

  // Brownout restarts readout as power-on does; only reset clears the mode register
  assign rst_int = reset || bo_s;

  // Power-up timer; reset pin held low until the part can serve data
  always_ff @(posedge clk) begin
    if (rst_int) begin
      pu_cnt_q <= '0;
      ready_q <= 1'b0;
    end else if (!ready_q) begin
      if (pu_cnt_q == PU_LAST) begin
        ready_q <= 1'b1;
      end
      pu_cnt_q <= pu_cnt_q + PW'(1);
    end
  end
  assign output_enable_reset_out = 1'b0;
  assign output_enable_reset_oe_n = ready_q;

  // Active only with reset pin high and enable low; pin sense is never inverted
  always_ff @(posedge clk) begin
    if (rst_int) begin
      act_q <= 1'b0;
    end else begin
      act_q <= oe_s && !ce_s && ready_q;
    end
  end

  // Standby whenever enable is high
  assign standby = ce_s;

  // Address counter feeding the FIFO; stops one past terminal_count
  assign w_valid = act_q && (addr_q != ADDR_END);
  assign w_word = {addr_q == ADDR_LAST, array_q[addr_q[AW-2:0]]};
  always_ff @(posedge clk) begin
    if (rst_int || !act_q) begin
      addr_q <= '0;
    end else if (w_valid && w_ready) begin
      addr_q <= addr_q + AW'(1);
    end
  end

  // Array loading; only while idle so a frame never sees a change
  always_ff @(posedge clk) begin
    if (prog_we && !act_q && {1'b0, prog_addr} < 17'(ARRAY_BYTES)) begin
      array_q[prog_addr[AW-2:0]] <= prog_data;
    end
  end

  // Control register; it shares nothing with the array
  always_ff @(posedge clk) begin
    if (reset) begin
      parallel_q <= cpr_pkg::MODE_PARALLEL_RESET;
    end else if (ctrl_wr) begin
      parallel_q <= ctrl_parallel;
    end
  end
  assign parallel_mode = parallel_q;

  // Reconfigure pulse; a repeat during a pulse is ignored
  always_ff @(posedge clk) begin
    if (rst_int) begin
      trig_active_q <= 1'b0;
      trig_cnt_q <= '0;
    end else if (!trig_active_q) begin
      if (jtag_update && jtag_instr == cpr_pkg::INSTR_RECONFIG) begin
        trig_active_q <= 1'b1;
        trig_cnt_q <= '0;
      end
    end else if (trig_cnt_q == TRIG_LAST) begin
      trig_active_q <= 1'b0;
    end else begin
      trig_cnt_q <= trig_cnt_q + 5'h01;
    end
  end
  assign config_trigger_n = !trig_active_q;

  // Pin enables; standby and reset both force float and cascade high
  always_ff @(posedge clk) begin
    if (rst_int) begin
      oe_n_q <= 1'b1;
      casc_n_q <= 1'b1;
    end else begin
      oe_n_q <= !(act_q && !done_s);
      casc_n_q <= !(act_q && done_s);
    end
  end
  assign data_lines_oe_n = oe_n_q;
  assign cascade_enable_out_n = casc_n_q;

  // Link side, clocked by config_clock
  logic [1:0] lk_s1_q, lk_s2_q;
  logic link_act, par_l;
  logic [2:0] bit_q;
  logic last_q;
  logic [7:0] data_q;
  logic r_valid, r_ready;
  logic [cpr_pkg::WORD_W-1:0] r_word;

  // Activity and mode cross as levels
  always_ff @(posedge config_clock) begin
    lk_s1_q <= {act_q, parallel_q};
    lk_s2_q <= lk_s1_q;
  end
  assign link_act = lk_s2_q[1];
  assign par_l = lk_s2_q[0];

  // Pop after the last bit of a byte, or every edge in parallel mode
  assign r_ready = link_act && !done_l_q && (par_l || bit_q == 3'h7);

  // One bit or one byte per rising edge that finds a FIFO word; an empty FIFO stalls it
  always_ff @(posedge config_clock) begin
    if (!link_act) begin
      bit_q <= '0;
      last_q <= 1'b0;
      done_l_q <= 1'b0;
      data_q <= '0;
    end else if (!done_l_q) begin
      if (r_valid) begin
        if (par_l) begin
          data_q <= r_word[7:0];
        end else begin
          data_q <= {7'h00, r_word[bit_q]};
        end
        bit_q <= (par_l || bit_q == 3'h7) ? 3'h0 : bit_q + 3'h1;
        if (r_ready) begin
          last_q <= r_word[cpr_pkg::LAST_POS];
        end
      end else if (last_q) begin
        done_l_q <= 1'b1;
      end
    end
  end
  assign data_lines_out = data_q;

  cpr_fifo #(
    .WIDTH(cpr_pkg::WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) cpr_fifo_i (
    .wclk(clk),
    .wrst(rst_int || !act_q),
    .w_valid(w_valid),
    .w_ready(w_ready),
    .w_data(w_word),
    .rclk(config_clock),
    .rrst(!link_act),
    .r_valid(r_valid),
    .r_ready(r_ready),
    .r_data(r_word)
  );

  // Checks; the pulse sequence spells out the nominal 16-cycle reconfigure width
  sequence s_trig_low_16;
    !config_trigger_n [*8] ##1 !config_trigger_n [*8] ##1 config_trigger_n;
  endsequence

  a_trig_pulse_len: assert property (@(posedge clk) disable iff (rst_int)
    $fell(config_trigger_n) |-> s_trig_low_16)
    else $error("reconfigure pulse length wrong");

  a_trig_instr_start: assert property (@(posedge clk) disable iff (rst_int)
    (jtag_update && jtag_instr == cpr_pkg::INSTR_RECONFIG && config_trigger_n)
    |=> $fell(config_trigger_n))
    else $error("reconfigure instruction did not start pulse");

  a_mode_write: assert property (@(posedge clk) disable iff (reset)
    ctrl_wr |=> parallel_mode == $past(ctrl_parallel))
    else $error("mode register did not take write");

  a_mode_serial_rst: assert property (@(posedge clk)
    reset |=> !parallel_mode)
    else $error("mode not serial after reset");

  a_idle_float: assert property (@(posedge clk) disable iff (rst_int)
    !act_q |=> data_lines_oe_n && cascade_enable_out_n)
    else $error("idle device drives data or cascade");

  a_standby_float: assert property (@(posedge clk) disable iff (rst_int)
    (ce_s && !act_q) |=> ##1 data_lines_oe_n)
    else $error("standby device drives data");

  a_addr_clear: assert property (@(posedge clk) disable iff (rst_int)
    !act_q |=> addr_q == '0)
    else $error("address not cleared");

  a_addr_hold: assert property (@(posedge clk) disable iff (rst_int)
    (act_q && addr_q == ADDR_END) ##1 act_q |-> addr_q == ADDR_END)
    else $error("address moved past terminal count");

  a_cascade_done: assert property (@(posedge clk) disable iff (rst_int)
    (act_q && done_s) ##1 act_q |-> !cascade_enable_out_n && data_lines_oe_n)
    else $error("cascade or float missing after last bit");

  a_powerup_drive: assert property (@(posedge clk)
    rst_int |=> !output_enable_reset_oe_n [*8])
    else $error("reset pin not held after power-up");

  a_brownout: assert property (@(posedge clk)
    bo_s |=> !act_q && !ready_q)
    else $error("brownout did not reset readout");

  // Counter and output shape guards; a wrong wrap would only show as a shifted stream
  a_trig_hold: assert property (@(posedge clk) disable iff (rst_int)
    (trig_active_q && trig_cnt_q != TRIG_LAST) |=> !config_trigger_n)
    else $error("reconfigure pulse ended early");

  a_addr_step: assert property (@(posedge clk) disable iff (rst_int)
    (w_valid && w_ready) |=> addr_q == $past(addr_q) + AW'(1))
    else $error("address did not advance on a taken word");

  a_bit_wrap: assert property (@(posedge config_clock)
    (link_act && !done_l_q && r_valid && !par_l && bit_q == 3'h7) |=> bit_q == 3'h0)
    else $error("bit counter did not wrap after a byte");

  a_serial_upper: assert property (@(posedge config_clock)
    (link_act && !par_l) |=> data_lines_out[7:1] == 7'h00)
    else $error("serial mode drives upper data lines");
endmodule : cpr_top

// ---- tb/cpr_fpga_model.sv ----
// Purpose: FPGA configuration master model for the readout block.
// Assumes: Mode pins all low, so this side sources config_clock.
// Notes: Clock stands low between frames; data is taken only while driven.
module cpr_fpga_model (
  input wire logic [7:0] data_lines_out,
  input wire logic data_lines_oe_n,
  output logic config_clock
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] got_q[$];

  initial config_clock = 1'b0;

  // Sample just before each rise, the value launched by the previous rise
  task automatic edges(input int n);
    repeat (n) begin
      #80;
      if (data_lines_oe_n === 1'b0) got_q.push_back(data_lines_out);
      config_clock = 1'b1;
      #80;
      config_clock = 1'b0;
    end
  endtask : edges
endmodule : cpr_fpga_model

// ---- tb/cpr_top_tb.sv ----
// Purpose: Self-checking bench for the configuration PROM readout block.
// Assumes: Power-up hold shortened to 20 cycles.
// Notes: Stream checks use the tail of the capture, skipping sync edges.
module cpr_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int PU = 20;
  localparam int NB = cpr_pkg::ARRAY_BYTES;
  logic clk, reset, init_low, chip_enable_n, supply_low, jtag_update, ctrl_wr;
  logic ctrl_parallel, prog_we;
  logic [7:0] jtag_instr, prog_data;
  logic [15:0] prog_addr;
  wire logic config_clock, pin, oe_out, oe_oe_n, casc_n, data_oe_n, trig_n, stby, par;
  wire logic [7:0] data;
  int fail_count = 0;
  int checks = 0;

  // Open-drain reset pin with pull-up; FPGA holds it low through init_low
  assign pin = ~((~oe_oe_n & ~oe_out) | init_low);

  cpr_top #(.POWERUP_CYCLES(PU)) cpr_top_i (.clk(clk), .reset(reset),
    .config_clock(config_clock), .output_enable_reset_in(pin),
    .output_enable_reset_out(oe_out), .output_enable_reset_oe_n(oe_oe_n),
    .chip_enable_n(chip_enable_n), .cascade_enable_out_n(casc_n),
    .data_lines_out(data), .data_lines_oe_n(data_oe_n), .config_trigger_n(trig_n),
    .supply_low(supply_low), .jtag_instr(jtag_instr), .jtag_update(jtag_update),
    .ctrl_wr(ctrl_wr), .ctrl_parallel(ctrl_parallel), .prog_we(prog_we),
    .prog_addr(prog_addr), .prog_data(prog_data), .standby(stby), .parallel_mode(par));

  cpr_fpga_model cpr_fpga_model_i (.data_lines_out(data), .data_lines_oe_n(data_oe_n),
    .config_clock(config_clock));

  // System clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : step

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  function automatic logic [7:0] pat(input int k);
    return 8'(k * 37 + 11);
  endfunction : pat

  task automatic report_and_stop;
    if (fail_count == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop

  task automatic t_powerup;
    step(10);
    chk(8'(oe_oe_n), 8'h00, "pin held");
    step(PU);
    chk(8'(oe_oe_n), 8'h01, "pin freed");
    chk(8'(par), 8'h00, "default mode");
  endtask : t_powerup

  task automatic t_reconf(input logic [7:0] code, input int exp_low);
    int low;
    low = 0;
    jtag_instr = code;
    jtag_update = 1'b1;
    step(1);
    jtag_update = 1'b0;
    repeat (24) begin
      low += int'(trig_n === 1'b0);
      step(1);
    end
    chk(8'(low), 8'(exp_low), "trigger width");
  endtask : t_reconf

  task automatic t_program;
    for (int k = 0; k < NB; k++) begin
      prog_we = 1'b1;
      prog_addr = 16'(k);
      prog_data = pat(k);
      step(1);
    end
    prog_we = 1'b0;
  endtask : t_program

  // One whole frame, then the terminal-count hold and the pin reset
  task automatic t_frame(input logic p);
    int n;
    int base;
    logic [7:0] got;
    cpr_fpga_model_i.got_q.delete();
    init_low = 1'b0;
    chip_enable_n = 1'b0;
    step(8);
    cpr_fpga_model_i.edges(p ? NB + 8 : NB * 8 + 8);
    step(8);
    n = cpr_fpga_model_i.got_q.size();
    base = n - (p ? NB : NB * 8);
    chk(8'(base >= 0), 8'h01, "sample count");
    for (int k = 0; k < NB && base >= 0; k++) begin
      if (p) got = cpr_fpga_model_i.got_q[base + k];
      else for (int i = 0; i < 8; i++) got[i] = cpr_fpga_model_i.got_q[base + 8 * k + i][0];
      chk(got, pat(k), "stream byte");
    end
    chk({6'h00, casc_n, data_oe_n}, 8'h01, "end of array");
    cpr_fpga_model_i.edges(3);
    step(1);
    chk(8'(cpr_fpga_model_i.got_q.size() - n), 8'h00, "hold past end");
    init_low = 1'b1;
    step(8);
    chk({6'h00, casc_n, data_oe_n}, 8'h03, "pin low");
    cpr_fpga_model_i.edges(6);
    step(1);
  endtask : t_frame

  task automatic t_mode;
    ctrl_parallel = 1'b1;
    ctrl_wr = 1'b1;
    step(1);
    ctrl_wr = 1'b0;
    step(1);
    chk(8'(par), 8'h01, "parallel set");
  endtask : t_mode

  task automatic t_standby;
    init_low = 1'b0;
    chip_enable_n = 1'b1;
    cpr_fpga_model_i.edges(4);
    step(1);
    chk({5'h00, stby, data_oe_n, casc_n}, 8'h07, "standby");
    init_low = 1'b1;
    step(6);
    chk({5'h00, stby, data_oe_n, casc_n}, 8'h07, "standby pin low");
  endtask : t_standby

  task automatic t_brown;
    supply_low = 1'b1;
    step(4);
    supply_low = 1'b0;
    step(4);
    chk({6'h00, par, oe_oe_n}, 8'h02, "brownout");
    step(PU + 6);
    chk(8'(oe_oe_n), 8'h01, "brownout release");
  endtask : t_brown

  // Main sequence
  initial begin
    {reset, init_low, chip_enable_n} = 3'b111;
    {supply_low, jtag_update, ctrl_wr, ctrl_parallel, prog_we} = 5'h00;
    jtag_instr = 8'h00;
    prog_data = 8'h00;
    prog_addr = 16'h0000;
    repeat (2) @(posedge clk);
    #2 reset = 1'b0;
    t_powerup();
    cpr_fpga_model_i.edges(6);
    step(1);
    t_reconf(8'hee, cpr_pkg::TRIG_CYCLES);
    t_reconf(8'hfe, 0);
    t_program();
    t_frame(1'b0);
    t_frame(1'b0);
    t_mode();
    t_frame(1'b1);
    t_standby();
    t_brown();
    report_and_stop();
  end

  // Watchdog, well beyond the expected run of about 0.2 ms
  initial begin
    #2000000;
    fail_count++;
    report_and_stop();
  end
endmodule : cpr_top_tb
